// >>> inc/s2u_defines.svh
`ifndef S2U_DEFINES_SVH
`define S2U_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define S2U_IDX_CONTROL 8'h8E
`define S2U_IDX_BUFFER  8'h8F
`define S2U_IDX_BAUD    8'h80

// Field positions inside the control register.
`define S2U_CTL_FMT    7
`define S2U_CTL_RXEN   4
`define S2U_CTL_TXB8   3
`define S2U_CTL_RXB8   2
`define S2U_CTL_TXDONE 1
`define S2U_CTL_RXDONE 0

// Bits of the control register that software can write and read back.
`define S2U_CTL_RW_MASK 8'h9F

// Reset values.
`define S2U_CTL_RST  8'h00
`define S2U_BUF_RST  8'h00
`define S2U_BAUD_RST 16'h043C

// System clock rate in MHz; the baud reset value gives about 115200 baud at this rate.
`define S2U_CLK_MHZ 125

`endif

// >>> inc/s2u_pkg.sv
package s2u_pkg;

  // One bus word.
  typedef logic [31:0] s2u_word_t;

  // One data byte of the port.
  typedef logic [7:0] s2u_byte_t;

  // Receiver states, one-hot.
  typedef enum logic [3:0]
  {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } s2u_rx_state_t;

endpackage

// >>> inc/s2u_tx_if.sv
`timescale 1ns/1ps
`default_nettype none

// Link between the register side and the transmit shifter.
interface s2u_tx_if #(parameter int DIV_W = 16);
  logic             ce;          // Clock enable.
  logic             start;       // One-cycle request to send a frame.
  logic             nine;        // Frame carries a ninth data bit.
  logic [8:0]       data;        // Ninth bit and data byte.
  logic [DIV_W-1:0] div;         // Bit period minus one, in clock cycles.
  logic             busy;        // A frame is on the line.
  logic             stop_pulse;  // One-cycle pulse as the stop bit begins.
  logic             txd;         // Serial output level.

  modport ctrl    (output ce, start, nine, data, div, input busy, stop_pulse, txd);
  modport shifter (input ce, start, nine, data, div, output busy, stop_pulse, txd);
endinterface

`default_nettype wire

// >>> verilog/s2u_tx.sv
`timescale 1ns/1ps
`default_nettype none

module s2u_tx #(parameter int DIV_W = 16)
(
  // Clock and reset.
  input  wire logic CLK_SYS_IN,
  input  wire logic RST_B_IN,
  // Link to the register side.
  s2u_tx_if.shifter tx
);
  import s2u_pkg::*;

  logic [10:0]      sh_q;     // Frame bits, start bit at the bottom.
  logic [3:0]       idx_q;    // Index of the bit on the line.
  logic [3:0]       last_q;   // Index of the stop bit.
  logic [DIV_W-1:0] cnt_q;    // Cycles left in the current bit.
  logic             busy_q;   // Frame in progress.
  logic             stop_q;   // Stop bit has just begun.
  logic             txd_q;    // Line level; idles high.
  logic             nine_q;   // Format latched for the frame.

  wire       tick     = busy_q && (cnt_q == '0);
  wire [3:0] idx_nxt  = idx_q + 4'h1;

  // The format is latched with the frame so that a change mid-frame cannot tear it.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_B_IN)
    begin
      sh_q   <= 11'h7FF;
      idx_q  <= 4'h0;
      last_q <= 4'h9;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      stop_q <= 1'b0;
      txd_q  <= 1'b1;
      nine_q <= 1'b0;
    end
    else if (tx.ce)
    begin
      stop_q <= 1'b0;
      if (tx.start && !busy_q)
      begin
        // Start bit, data LSB first, optional ninth bit, stop bit.
        sh_q   <= tx.nine ? {1'b1, tx.data, 1'b0} : {2'b11, tx.data[7:0], 1'b0};
        last_q <= tx.nine ? 4'hA : 4'h9;
        nine_q <= tx.nine;
        idx_q  <= 4'h0;
        cnt_q  <= tx.div;
        busy_q <= 1'b1;
        txd_q  <= 1'b0;
      end
      else if (tick)
      begin
        cnt_q <= tx.div;
        if (idx_q == last_q)
        begin
          // Stop bit complete; the line stays high.
          busy_q <= 1'b0;
        end
        else
        begin
          idx_q  <= idx_nxt;
          txd_q  <= sh_q[idx_nxt];
          stop_q <= (idx_nxt == last_q);
        end
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign tx.busy       = busy_q;
  assign tx.stop_pulse = stop_q;
  assign tx.txd        = txd_q;

  // A frame opens with a low start bit.
  property p_tx_start;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN || !tx.ce)
      (tx.start && !busy_q) |=> (!txd_q && busy_q);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("Start bit not low.");

  // In nine-bit frames the bit before the stop bit is the ninth data bit.
  property p_tx_ninth;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN || !tx.ce)
      (stop_q && nine_q) |-> ($past(txd_q) == sh_q[9]) && txd_q;
  endproperty
  a_tx_ninth: assert property (p_tx_ninth) else $error("Ninth bit wrong.");

endmodule

`default_nettype wire

// >>> verilog/s2u_top.sv
`include "s2u_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module s2u_top #(parameter int DIV_W = 16)
(
  // Clock, reset and clock enable.
  input  wire logic              CLK_SYS_IN,
  input  wire logic              RST_B_IN,
  input  wire logic              CE_IN,
  // AHB-Lite slave port.
  input  wire logic              HSEL_IN,
  input  wire s2u_pkg::s2u_word_t HADDR_IN,
  input  wire logic [1:0]        HTRANS_IN,
  input  wire logic              HWRITE_IN,
  input  wire logic [2:0]        HSIZE_IN,
  input  wire logic              HREADY_IN,
  input  wire s2u_pkg::s2u_word_t HWDATA_IN,
  output var  s2u_pkg::s2u_word_t HRDATA_OUT,
  output var  logic              HREADYOUT_OUT,
  output var  logic              HRESP_OUT,
  // Serial lines.
  input  wire logic              RXD_IN,
  output var  logic              TXD_OUT
);
  import s2u_pkg::*;

  // Refused at elaboration: narrower counters cannot pace a bit, wider ones only waste flops.
  if (DIV_W < 2 || DIV_W > 24)
    $error("DIV_W must lie between 2 and 24.");
  // True when a bus address selects the given register index.
  function automatic logic hit(input s2u_word_t addr, input logic [7:0] idx);
    hit = (addr[31:10] == 22'h0) && (addr[9:2] == idx);
  endfunction

  s2u_tx_if #(.DIV_W(DIV_W)) tx_link ();
  s2u_tx #(.DIV_W(DIV_W)) u_tx
  (
    .CLK_SYS_IN (CLK_SYS_IN),
    .RST_B_IN   (RST_B_IN),
    .tx         (tx_link.shifter)
  );
  logic [7:0]       ctl_q;        // Control register.
  s2u_byte_t        rx_buf_q;     // Received byte, kept apart from the send path.
  logic [DIV_W-1:0] baud_q;       // Bit period minus one.
  logic             wr_pend_q;    // Write data phase in progress.
  logic             rd_pend_q;    // Read wait state in progress.
  logic [7:0]       idx_q;        // Register index of the pending transfer.
  logic             map_q;        // Pending transfer hits a register.
  s2u_word_t        hrdata_q;     // Read data.
  logic             hready_q;     // Ready to the master.
  logic             tx_start_q;   // Request to the shifter.
  s2u_byte_t        tx_buf_q;     // Byte to be sent.

  // Address-phase decode.
  wire       addr_ok  = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  wire       map_in   = hit(HADDR_IN, `S2U_IDX_CONTROL) || hit(HADDR_IN, `S2U_IDX_BUFFER)
                        || hit(HADDR_IN, `S2U_IDX_BAUD);
  wire [7:0] idx_in   = HADDR_IN[9:2];
  // Data-phase strobes.
  wire       wr_ctl   = wr_pend_q && map_q && (idx_q == `S2U_IDX_CONTROL);
  wire       wr_buf   = wr_pend_q && map_q && (idx_q == `S2U_IDX_BUFFER);
  wire       wr_baud  = wr_pend_q && map_q && (idx_q == `S2U_IDX_BAUD);
  wire [7:0] wdat     = HWDATA_IN[7:0];
  // Read selection; unmapped words read as zero.
  wire s2u_word_t rd_mux = !map_q ? 32'h0000_0000 :
                           (idx_q == `S2U_IDX_CONTROL) ? {24'h0, ctl_q} :
                           (idx_q == `S2U_IDX_BUFFER)  ? {24'h0, rx_buf_q} :
                           32'({baud_q});
  // Reads take one wait state so that a write in the cycle before is seen.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_B_IN)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 8'h00;
      map_q     <= 1'b0;
      hrdata_q  <= 32'h0000_0000;
      hready_q  <= 1'b1;
      HRESP_OUT <= 1'b0; // Only OKAY exists, so reset alone sets this flop.
    end
    else if (CE_IN)
    begin
      wr_pend_q <= addr_ok && HWRITE_IN;
      if (addr_ok)
      begin
        idx_q <= idx_in;
        map_q <= map_in;
      end
      if (addr_ok && !HWRITE_IN)
      begin
        rd_pend_q <= 1'b1;
        hready_q  <= 1'b0;
      end
      else if (rd_pend_q)
      begin
        rd_pend_q <= 1'b0;
        hready_q  <= 1'b1;
        hrdata_q  <= rd_mux;
      end
    end
  end

  assign HRDATA_OUT    = hrdata_q;
  assign HREADYOUT_OUT = hready_q;

  // Receive input: three flops, the level changes once the last two agree.
  logic       rx_s1_q;
  logic       rx_s2_q;
  logic       rx_s3_q;
  logic       rx_lvl_q;     // Filtered line level.
  logic       rx_prev_q;    // Filtered level one cycle back.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_B_IN)
    begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_s3_q   <= 1'b1;
      rx_lvl_q  <= 1'b1;
      rx_prev_q <= 1'b1;
    end
    else if (CE_IN)
    begin
      rx_s1_q   <= RXD_IN;
      rx_s2_q   <= rx_s1_q;
      rx_s3_q   <= rx_s2_q;
      rx_prev_q <= rx_lvl_q;
      if (rx_s2_q == rx_s3_q)
        rx_lvl_q <= rx_s3_q;
    end
  end
  // Receiver.
  s2u_rx_state_t    rx_st_q;
  logic [DIV_W-1:0] rx_cnt_q;    // Cycles to the next sample point.
  logic [3:0]       rx_bit_q;    // Data bits taken so far.
  logic [8:0]       rx_sh_q;     // Incoming bits shift in from the top.
  wire       rx_en    = ctl_q[`S2U_CTL_RXEN];
  wire       nine     = ctl_q[`S2U_CTL_FMT];
  wire       rx_tick  = (rx_cnt_q == '0);
  wire [3:0] rx_last  = nine ? 4'h8 : 4'h7;
  wire       rx_fall  = rx_prev_q && !rx_lvl_q;
  wire       rx_stop  = (rx_st_q == RX_STOP) && rx_tick && rx_en;

  // Sampling sits mid-bit: half a period after the falling edge, then whole periods.
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_B_IN)
    begin
      rx_st_q  <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 9'h000;
    end
    else if (CE_IN)
    begin
      rx_cnt_q <= rx_cnt_q - 1'b1;
      if (!rx_en)
        rx_st_q <= RX_IDLE;
      else
      begin
        unique case (rx_st_q)
          RX_IDLE:
          begin
            if (rx_fall)
            begin
              rx_st_q  <= RX_START;
              rx_cnt_q <= baud_q >> 1;
            end
          end
          RX_START:
          begin
            // A start bit that is high again at mid-bit was a glitch.
            if (rx_tick)
            begin
              rx_st_q  <= rx_lvl_q ? RX_IDLE : RX_DATA;
              rx_cnt_q <= baud_q;
              rx_bit_q <= 4'h0;
            end
          end
          RX_DATA:
          begin
            if (rx_tick)
            begin
              rx_sh_q  <= {rx_lvl_q, rx_sh_q[8:1]};
              rx_bit_q <= rx_bit_q + 4'h1;
              rx_cnt_q <= baud_q;
              if (rx_bit_q == rx_last)
                rx_st_q <= RX_STOP;
            end
          end
          RX_STOP:
            if (rx_tick)
              rx_st_q <= RX_IDLE;
        endcase
      end
    end
  end

  // Control, buffer and baud registers; hardware sets win over software clears.
  wire tx_set = tx_link.stop_pulse;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_B_IN)
    begin
      ctl_q      <= `S2U_CTL_RST;
      rx_buf_q   <= `S2U_BUF_RST;
      tx_buf_q   <= `S2U_BUF_RST;
      baud_q     <= DIV_W'(`S2U_BAUD_RST);
      tx_start_q <= 1'b0;
    end
    else if (CE_IN)
    begin
      tx_start_q <= 1'b0;
      if (wr_ctl)
        ctl_q <= wdat & `S2U_CTL_RW_MASK;
      if (wr_baud)
        baud_q <= HWDATA_IN[DIV_W-1:0];
      if (wr_buf && !tx_link.busy)
      begin
        // The send path only; the received byte is untouched.
        tx_buf_q   <= wdat;
        tx_start_q <= 1'b1;
      end
      if (tx_set)
        ctl_q[`S2U_CTL_TXDONE] <= 1'b1;
      if (rx_stop)
      begin
        ctl_q[`S2U_CTL_RXDONE] <= 1'b1;
        rx_buf_q <= nine ? rx_sh_q[7:0] : rx_sh_q[8:1];
        if (nine)
          ctl_q[`S2U_CTL_RXB8] <= rx_sh_q[8];
      end
    end
  end

  // Shifter hook-up; the ninth bit is taken from the control register.
  assign tx_link.ce    = CE_IN;
  assign tx_link.start = tx_start_q;
  assign tx_link.nine  = nine;
  assign tx_link.data  = {ctl_q[`S2U_CTL_TXB8], tx_buf_q};
  assign tx_link.div   = baud_q;
  assign TXD_OUT       = tx_link.txd;

  // On entering the stop state the frame has taken exactly as many data samples as its format.
  property p_fmt_bits;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN || !CE_IN)
      (rx_st_q == RX_DATA) ##1 (rx_st_q == RX_STOP) |-> (rx_bit_q == (nine ? 4'h9 : 4'h8));
  endproperty
  a_fmt_bits: assert property (p_fmt_bits) else $error("Bit count wrong.");
  // The received ninth bit lands in the control register.
  property p_rx_ninth;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN || !CE_IN)
      (rx_stop && nine) |=> (ctl_q[`S2U_CTL_RXB8] == $past(rx_sh_q[8]));
  endproperty
  a_rx_ninth: assert property (p_rx_ninth) else $error("Ninth bit lost.");
  // Receive-done rises at the stop-bit sample and only a control write can take it down.
  property p_rx_done;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN || !CE_IN)
      rx_stop |=> ctl_q[`S2U_CTL_RXDONE] ##1 (ctl_q[`S2U_CTL_RXDONE] || $past(wr_ctl));
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("Receive flag missed.");
  // Transmit-done follows the start of the stop bit.
  property p_tx_done;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN || !CE_IN)
      tx_set |=> ctl_q[`S2U_CTL_TXDONE];
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("Transmit flag missed.");
  // A buffer read returns the received byte.
  property p_buf_read;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN || !CE_IN)
      (rd_pend_q && map_q && idx_q == `S2U_IDX_BUFFER) |=> (hrdata_q == {24'h0, $past(rx_buf_q)});
  endproperty
  a_buf_read: assert property (p_buf_read) else $error("Buffer read wrong.");
  // A buffer write leaves the received byte alone.
  property p_buf_split;
    @(posedge CLK_SYS_IN) disable iff (!RST_B_IN || !CE_IN)
      (wr_buf && !rx_stop) |=> $stable(rx_buf_q);
  endproperty
  a_buf_split: assert property (p_buf_split) else $error("Receive byte overwritten.");

endmodule

`default_nettype wire

// >>> testbench/s2u_peer.sv
`timescale 1ns/1ps
`default_nettype none

// Remote serial peer: sends frames to the port and decodes the frames it sends.
module s2u_peer #(parameter int BIT = 8)
(
  // Clock.
  input  wire logic       clk_in,
  // Serial lines and frame format.
  input  wire logic       line_in,
  input  wire logic       nine_in,
  output var  logic       line_out,
  // Decoded frame: stop level, ninth bit, byte.
  output var  logic       got_out,
  output var  logic [9:0] data_out
);
  logic [9:0] bits;  // Samples of one incoming frame.

  // The line idles high between frames.
  initial
  begin
    line_out = 1'b1;
    got_out  = 1'b0;
    data_out = 10'h000;
  end

  // Sample every bit after the start bit near its middle so that a slip of a cycle or two still decodes.
  always
  begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk_in);
    bits = 10'h000;
    for (int i = 0; i < (nine_in ? 10 : 9); i++)
    begin
      repeat (BIT) @(posedge clk_in);
      bits[i] = line_in;
    end
    data_out <= nine_in ? bits : {bits[8], 1'b0, bits[7:0]};
    got_out  <= 1'b1;
    @(posedge clk_in);
    got_out  <= 1'b0;
  end

  // Send one frame: low start, data LSB first, ninth bit if asked, high stop.
  task automatic send(input logic [8:0] d, input logic nine);
    logic [10:0] f;
    f = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      line_out <= f[i];
      repeat (BIT) @(posedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

// >>> testbench/s2u_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "s2u_defines.svh"

// Compare two values once each, count, and report a mismatch at once.
`define CHK(a, e) \
  begin \
    logic [31:0] got_v; \
    logic [31:0] exp_v; \
    got_v = 32'(a); \
    exp_v = 32'(e); \
    compares++; \
    if (got_v !== exp_v) \
    begin \
      num_errors++; \
      $display("CHECK FAILED at %0t got %h expected %h", $time, got_v, exp_v); \
    end \
  end

module s2u_top_test;
  import s2u_pkg::*;
  localparam int        BIT    = 8;                            // Baud register 7.
  localparam s2u_word_t A_CTL  = 32'(`S2U_IDX_CONTROL) << 2;  // Control word.
  localparam s2u_word_t A_BUF  = 32'(`S2U_IDX_BUFFER) << 2;   // Buffer word.
  localparam s2u_word_t A_BAUD = 32'(`S2U_IDX_BAUD) << 2;     // Baud word.
  localparam s2u_word_t A_BAD  = 32'h00000300;                 // Unmapped.

  logic       clk    = 1'b0;   // System clock.
  logic       rst_b  = 1'b0;   // Reset, active low.
  logic       hsel   = 1'b0;   // Bus master signals.
  logic [1:0] htrans = 2'h0;
  logic       hwrite = 1'b0;
  s2u_word_t  haddr  = 32'h0;
  s2u_word_t  hwdata = 32'h0;
  s2u_word_t  hrdata;          // Slave answers.
  logic       hreadyout;
  logic       hresp;
  logic       rxd;             // Serial lines.
  logic       txd;
  logic       got;             // Peer decoded a frame.
  logic [9:0] frame;
  logic       nine   = 1'b0;   // Peer frame format.
  logic       rd_dp  = 1'b0;   // A read data phase is running.
  s2u_word_t  rdq[$];          // Expected read data, oldest first.
  logic [9:0] txq[$];          // Expected outgoing frames.
  s2u_word_t  ctl;
  s2u_byte_t  b;
  int         num_errors = 0;
  int         compares   = 0;

  // Free-running clock, 8 ns period.
  always #4 clk = ~clk;

  s2u_top #(.DIV_W(16)) s2u_top_i
  (
    .CLK_SYS_IN    (clk),
    .RST_B_IN      (rst_b),
    .CE_IN         (1'b1),
    .HSEL_IN       (hsel),
    .HADDR_IN      (haddr),
    .HTRANS_IN     (htrans),
    .HWRITE_IN     (hwrite),
    .HSIZE_IN      (3'h2),
    .HREADY_IN     (hreadyout),
    .HWDATA_IN     (hwdata),
    .HRDATA_OUT    (hrdata),
    .HREADYOUT_OUT (hreadyout),
    .HRESP_OUT     (hresp),
    .RXD_IN        (rxd),
    .TXD_OUT       (txd)
  );

  s2u_peer #(.BIT(BIT)) s2u_peer_i
  (
    .clk_in   (clk),
    .line_in  (txd),
    .nine_in  (nine),
    .line_out (rxd),
    .got_out  (got),
    .data_out (frame)
  );

  // One single transfer; the waits are only bounded by the watchdog.
  task automatic bus(input logic wr, input s2u_word_t a, input s2u_word_t d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input s2u_word_t a, input s2u_word_t d);
    bus(1'b1, a, d);
  endtask

  // Note the expected word, then read; the monitor compares.
  task automatic rd(input s2u_word_t a, input s2u_word_t e);
    rdq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Wait up to 300 cycles for every expected frame to be seen, then check that none is left.
  task automatic drain();
    for (int i = 0; i < 300 && txq.size() != 0; i++)
      @(posedge clk);
    `CHK(txq.size(), 0)
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Monitor: pairs each finished read and each decoded frame with its note.
  always @(posedge clk)
  begin
    if (hreadyout === 1'b1)
    begin
      if (rd_dp)
      begin
        `CHK(hrdata, rdq.size() != 0 ? rdq.pop_front() : 32'hFFFFFFFF)
        `CHK(hresp, 1'b0)
      end
      rd_dp = hsel & htrans[1] & ~hwrite;
    end
    if (got === 1'b1)
      `CHK(frame, txq.size() != 0 ? 32'(txq.pop_front()) : 32'hFFFFFFFF)
  end

  // A full run takes under two thousand cycles; this limit means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    void'($urandom(32'hE41C878E));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(A_CTL, 32'h0);
    rd(A_BUF, 32'h0);
    rd(A_BAUD, 32'h043C);
    wr(A_BAD, 32'hFFFFFFFF);
    rd(A_BAD, 32'h0);
    wr(A_BAUD, 32'h7);
    rd(A_BAUD, 32'h7);
    wr(A_CTL, 32'hFF);
    rd(A_CTL, 32'h9F);
    // Transmit in both formats with both ninth-bit values.
    for (int m = 0; m < 4; m++)
    begin
      b    = 8'($urandom);
      ctl  = 32'({m[1], 3'h0, m[0], 3'h0});
      nine = m[1];
      wr(A_CTL, ctl);
      txq.push_back({1'b1, m[1] & m[0], b});
      wr(A_BUF, 32'(b));
      rd(A_CTL, ctl);
      wr(A_BUF, 32'(~b));
      drain();
      rd(A_CTL, ctl | 32'h2);
      repeat (40) @(posedge clk);
      rd(A_CTL, ctl | 32'h2);
    end
    // Receive in both formats; a transmit write must not disturb the received byte.
    for (int m = 0; m < 4; m++)
    begin
      b    = 8'($urandom);
      ctl  = 32'({m[1], 3'h1, 4'h0});
      nine = m[1];
      wr(A_CTL, ctl);
      s2u_peer_i.send({m[0], b}, m[1]);
      repeat (BIT) @(posedge clk);
      rd(A_CTL, ctl | 32'h1 | 32'({m[1] & m[0], 2'h0}));
      rd(A_BUF, 32'(b));
      txq.push_back({2'b10, ~b});
      wr(A_BUF, 32'(~b));
      rd(A_BUF, 32'(b));
      drain();
    end
    // Reception switched off: the frame leaves flag and buffer alone.
    wr(A_CTL, 32'h0);
    s2u_peer_i.send(9'h0A5, 1'b0);
    repeat (BIT) @(posedge clk);
    rd(A_CTL, 32'h0);
    rd(A_BUF, 32'(b));
    close_out();
  end
endmodule

`default_nettype wire
